// ===== core/tir_pkg.sv
/*
 * Package for the timer interrupt request logic: constants, state encoding
 * and the packed structs that carry the CPU context and acceptance signals.
 * Assumes a single 125 MHz system clock and a synchronous active-low reset.
 */
package tir_pkg;

    // ********************************************************************
    // register map of the plain software port
    // ********************************************************************
    localparam logic [3:0] ADDR_PEND   = 4'h0; // pending flag, bit 0
    localparam logic [3:0] ADDR_PERMIT = 4'h1; // permit flag, bit 0
    localparam logic [3:0] ADDR_SEL    = 4'h2; // pulse select, bits 1:0
    localparam logic [3:0] ADDR_STATUS = 4'h3; // global on, in service, ce
    localparam int         DATA_W      = 4;
    localparam int         SEL_W       = 2;
    localparam int         NUM_PULSES  = 4;

    // ********************************************************************
    // reset values and vector
    // ********************************************************************
    localparam logic [DATA_W-1:0] DATA_ZERO   = 4'h0;
    localparam logic [SEL_W-1:0]  SEL_RESET   = 2'h0;
    localparam logic [13:0]       TIMER_VECT  = 14'h0003;
    localparam logic [1:0]        VECT_SEG    = 2'h0;
    localparam int                PC_W        = 14;
    localparam int                BANK_W      = 4;
    localparam int                STACK_DEPTH = 7;
    localparam logic [2:0]        SP_RESET    = 3'h0;
    localparam logic [2:0]        SP_ONE      = 3'h1;

    // ********************************************************************
    // timing: carry set pulse trails the interrupt pulse fall by 10 ms
    // ********************************************************************
    localparam int CLK_MHZ        = 125;
    localparam int CARRY_DELAY_MS = 10;
    localparam int CARRY_DELAY_CYC = CARRY_DELAY_MS * 1000 * CLK_MHZ;
    localparam int DLY_W          = 21;

    // ********************************************************************
    // types
    // ********************************************************************
    typedef enum logic [1:0] {
        TIR_IDLE    = 2'b00,
        TIR_SERVICE = 2'b01
    } tir_state_t;

    typedef struct packed {
        logic [PC_W-1:0]   pc;
        logic [BANK_W-1:0] bank;
        logic              idx_en;
    } tir_ctx_t;

    typedef struct packed {
        logic              take;     // one-cycle acceptance strobe
        logic [1:0]        seg;
        logic [PC_W-1:0]   vector;
    } tir_accept_t;

endpackage

// ===== core/tir_timer_irq.sv
/*
 * Timer interrupt request logic: edge detect, pending flag, acceptance,
 * context stack and chip-enable reset synchronised to the carry set pulse.
 * Assumes the timer pulses and CE pin are asynchronous pins, the carry set
 * pulse is generated here, and the CPU sequencer presents one-cycle instruction strobes.
 */
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
// Overview of operation
// RULE1: request on falling edge of selected pulse
// RULE2: each request sets the pending flag
// RULE3: accept needs pending, global on, permit
// RULE4: vector to address 0003H segment 0
// RULE5: acceptance clears the pending flag
// RULE6: disabled pending flag stays until enabled
// RULE7: software write 0 cancels request
// RULE8: software write 1 acts as request
// RULE9: acceptance pushes one stack level
// RULE10: bank and index enable saved too
// RULE11: return only via return instruction pop
// RULE12: acceptance enters global-off; later requests wait
// RULE13: select change falling pulse raises request
// RULE14: clear beats coincident falling edge
// RULE15: ce reset on next carry set edge
// RULE16: ce reset beats coincident request
// RULE17: ce reset clears pending flag
// RULE18: carry set rises 10 ms after fall
// RULE19: software finishes service within one period
// RULE20: ce reset only after ce rises
// RULE21: return restores bank and index enable
// RULE22: registered edge detect, one-cycle set
module tir_timer_irq
    import tir_pkg::*;
(
    input  wire logic                  CLK_SYS_I,
    input  wire logic                  NRST_I,
    input  wire logic [NUM_PULSES-1:0] PULSE_I,
    input  wire logic                  CE_PIN_I,
    input  wire logic [3:0]            REG_ADDR_I,
    input  wire logic [DATA_W-1:0]     REG_WDATA_I,
    input  wire logic                  REG_WR_I,
    input  wire logic                  REG_RD_I,
    output logic [DATA_W-1:0]          REG_RDATA_O,
    input  wire logic                  GLOBAL_INT_ON_INSTR_I,
    input  wire logic                  GLOBAL_INT_OFF_INSTR_I,
    input  wire logic                  RETURN_FROM_IRQ_INSTR_I,
    input  wire logic                  CPU_READY_I,
    input  wire tir_pkg::tir_ctx_t     CPU_CTX_I,
    output tir_pkg::tir_accept_t       ACCEPT_O,
    output tir_pkg::tir_ctx_t          RESTORE_CTX_O,
    output logic                       RESTORE_O,
    output logic                       CARRY_SET_O,
    output logic                       CE_RESET_O,
    output logic                       GLOBAL_INT_OFF_STATE_O,
    output logic                       TIMER_IRQ_PENDING_O
);
    import tir_pkg::*;

    // ********************************************************************
    // pin synchronisers
    // ********************************************************************
    logic [NUM_PULSES-1:0] pulse_s1_r, pulse_s2_r;
    logic                  ce_s1_r, ce_s2_r, ce_prev_r;

    // two flops on every asynchronous pin
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            pulse_s1_r <= '0;
            pulse_s2_r <= '0;
            ce_s1_r    <= 1'b0;
            ce_s2_r    <= 1'b0;
            ce_prev_r  <= 1'b0;
        end else begin
            pulse_s1_r <= PULSE_I;
            pulse_s2_r <= pulse_s1_r;
            ce_s1_r    <= CE_PIN_I;
            ce_s2_r    <= ce_s1_r;
            ce_prev_r  <= ce_s2_r;
        end
    end

    // ********************************************************************
    // software-visible control
    // ********************************************************************
    logic [SEL_W-1:0] sel_r;
    logic             permit_r;
    logic             pend_r;
    logic             glob_on_r;
    logic             sel_pulse_prev_r;
    logic             sel_pulse;
    logic             fall_set;
    logic             wr_pend, wr_permit, wr_sel;
    logic             accept;
    logic             ce_reset;
    tir_state_t       state_r;

    // if/else decode of the plain write port
    always_comb begin
        wr_pend   = 1'b0;
        wr_permit = 1'b0;
        wr_sel    = 1'b0;
        if (REG_WR_I && REG_ADDR_I == ADDR_PEND) begin
            wr_pend = 1'b1;
        end else if (REG_WR_I && REG_ADDR_I == ADDR_PERMIT) begin
            wr_permit = 1'b1;
        end else if (REG_WR_I && REG_ADDR_I == ADDR_SEL) begin
            wr_sel = 1'b1;
        end
    end

    // permit and pulse selection; ce reset restores defaults
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I || ce_reset) begin
            permit_r <= 1'b0;
            sel_r    <= SEL_RESET;
        end else begin
            if (wr_permit) permit_r <= REG_WDATA_I[0];
            if (wr_sel)    sel_r    <= REG_WDATA_I[SEL_W-1:0];
        end
    end

    // ********************************************************************
    // falling edge detection on the selected pulse
    // ********************************************************************
    // the previous sample is of the selected mux output, so a select
    // change from a high pulse to a low one reads as a fall
    assign sel_pulse = pulse_s2_r[sel_r];                          // [RULE13]

    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            sel_pulse_prev_r <= 1'b0;
        end else begin
            sel_pulse_prev_r <= sel_pulse;                         // [RULE22]
        end
    end

    assign fall_set = sel_pulse_prev_r && !sel_pulse;     // [RULE1] [RULE22]

    // ********************************************************************
    // pending flag
    // ********************************************************************
    // priority: ce reset, then software write, then edge, then accept;
    // a written 0 beats a coincident fall, a held flag waits for enables
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            pend_r <= 1'b0;
        end else if (ce_reset) begin
            pend_r <= 1'b0;                              // [RULE16] [RULE17]
        end else if (wr_pend && !REG_WDATA_I[0]) begin
            pend_r <= 1'b0;                               // [RULE7] [RULE14]
        end else if (wr_pend && REG_WDATA_I[0]) begin
            pend_r <= 1'b1;                                        // [RULE8]
        end else if (fall_set) begin
            pend_r <= 1'b1;                                        // [RULE2]
        end else if (accept) begin
            pend_r <= 1'b0;                                        // [RULE5]
        end
    end

    // ********************************************************************
    // acceptance and global enable
    // ********************************************************************
    // no nesting: a request during service waits for the return, even
    // when the routine re-enables just before it
    assign accept = pend_r && glob_on_r && permit_r && CPU_READY_I
                    && state_r == TIR_IDLE                       // [RULE12]
                    && !ce_reset && !wr_pend;           // [RULE3] [RULE6]

    // enable instr turns on; accept or disable instr turns off
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I || ce_reset) begin
            glob_on_r <= 1'b0;
        end else if (accept) begin
            glob_on_r <= 1'b0;                                    // [RULE12]
        end else if (GLOBAL_INT_OFF_INSTR_I) begin
            glob_on_r <= 1'b0;
        end else if (GLOBAL_INT_ON_INSTR_I) begin
            glob_on_r <= 1'b1;
        end
    end

    // ********************************************************************
    // context stack
    // ********************************************************************
    tir_ctx_t stack_r [STACK_DEPTH];
    logic [2:0] sp_r;
    logic       pop;

    // pop only on the return instruction with a level in use
    assign pop = RETURN_FROM_IRQ_INSTR_I && sp_r != SP_RESET;     // [RULE11]

    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I || ce_reset) begin
            sp_r <= SP_RESET;
        end else if (accept) begin
            sp_r <= sp_r + SP_ONE;                                 // [RULE9]
        end else if (pop) begin
            sp_r <= sp_r - SP_ONE;
        end
    end

    // one generate per stack entry; overflow beyond depth is dropped
    genvar gi;
    generate
        for (gi = 0; gi < STACK_DEPTH; gi++) begin : g_stack
            always_ff @(posedge CLK_SYS_I) begin
                if (!NRST_I) begin
                    stack_r[gi] <= '0;
                end else if (accept && sp_r == 3'(gi)) begin
                    stack_r[gi] <= CPU_CTX_I;                     // [RULE10]
                end
            end
        end
    endgenerate

    // service tracking for status read
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I || ce_reset) begin
            state_r <= TIR_IDLE;
        end else begin
            case (state_r)
                TIR_IDLE:    if (accept) state_r <= TIR_SERVICE;
                TIR_SERVICE: if (pop && sp_r == SP_ONE) state_r <= TIR_IDLE;
                default:     state_r <= TIR_IDLE;
            endcase
        end
    end

    // registered acceptance and restore outputs
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            ACCEPT_O      <= '0;
            RESTORE_O     <= 1'b0;
            RESTORE_CTX_O <= '0;
        end else begin
            ACCEPT_O.take   <= accept;
            ACCEPT_O.seg    <= VECT_SEG;                           // [RULE4]
            ACCEPT_O.vector <= TIMER_VECT;                         // [RULE4]
            RESTORE_O       <= pop;
            if (pop) begin
                RESTORE_CTX_O <= stack_r[sp_r - SP_ONE];          // [RULE21]
            end
        end
    end

    // ********************************************************************
    // carry set pulse, delayed from the pulse fall
    // ********************************************************************
    // a fixed lag lets a short service routine finish before ce reset
    localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(CARRY_DELAY_CYC - 1);
    logic [DLY_W-1:0] dly_cnt_r;
    logic             dly_run_r;
    logic             carry_set_r;
    logic             ce_armed_r;
    logic             ce_reset_r;

    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            dly_cnt_r   <= '0;
            dly_run_r   <= 1'b0;
            carry_set_r <= 1'b0;
        end else begin
            carry_set_r <= 1'b0;
            if (fall_set) begin
                dly_run_r <= 1'b1;
                dly_cnt_r <= '0;
            end else if (dly_run_r && dly_cnt_r == DLY_LAST) begin
                dly_run_r   <= 1'b0;
                carry_set_r <= 1'b1;                              // [RULE18]
            end else if (dly_run_r) begin
                dly_cnt_r <= dly_cnt_r + 1'b1;
            end
        end
    end

    // arm on ce rise, fire on the next carry set pulse
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            ce_armed_r <= 1'b0;
        end else if (ce_s2_r && !ce_prev_r) begin
            ce_armed_r <= 1'b1;                                   // [RULE20]
        end else if (carry_set_r) begin
            ce_armed_r <= 1'b0;
        end
    end

    assign ce_reset = ce_armed_r && carry_set_r;                  // [RULE15]

    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            ce_reset_r <= 1'b0;
        end else begin
            ce_reset_r <= ce_reset;
        end
    end

    // ********************************************************************
    // read port, data one cycle after the strobe
    // ********************************************************************
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            REG_RDATA_O <= DATA_ZERO;
        end else if (!REG_RD_I) begin
            REG_RDATA_O <= DATA_ZERO;
        end else if (REG_ADDR_I == ADDR_PEND) begin
            REG_RDATA_O <= {3'h0, pend_r};
        end else if (REG_ADDR_I == ADDR_PERMIT) begin
            REG_RDATA_O <= {3'h0, permit_r};
        end else if (REG_ADDR_I == ADDR_SEL) begin
            REG_RDATA_O <= {2'h0, sel_r};
        end else if (REG_ADDR_I == ADDR_STATUS) begin
            REG_RDATA_O <= {1'b0, ce_s2_r, state_r == TIR_SERVICE,
                            glob_on_r};
        end else begin
            REG_RDATA_O <= DATA_ZERO; // unmapped reads as zero
        end
    end

    assign CARRY_SET_O            = carry_set_r;
    assign CE_RESET_O             = ce_reset_r;
    assign GLOBAL_INT_OFF_STATE_O = !glob_on_r;
    assign TIMER_IRQ_PENDING_O    = pend_r;

    // ********************************************************************
    // checks
    // ********************************************************************
    accept_needs_all_a: assert property (@(posedge CLK_SYS_I)          // [RULE3]
        disable iff (!NRST_I) ACCEPT_O.take |->
        $past(pend_r) && $past(permit_r) && $past(glob_on_r))
        else $error("accept without enables");
    vector_fixed_a: assert property (@(posedge CLK_SYS_I)              // [RULE4]
        disable iff (!NRST_I) ACCEPT_O.take |->
        ACCEPT_O.vector == TIMER_VECT && ACCEPT_O.seg == VECT_SEG)
        else $error("wrong vector");
    accept_clears_a: assert property (@(posedge CLK_SYS_I)             // [RULE5]
        disable iff (!NRST_I) accept && !fall_set |=> !pend_r)
        else $error("pending not cleared");
    accept_disables_a: assert property (@(posedge CLK_SYS_I)          // [RULE12]
        disable iff (!NRST_I) accept |=> !glob_on_r ##1 !ACCEPT_O.take)
        else $error("global not off");
    fall_sets_pend_a: assert property (@(posedge CLK_SYS_I)            // [RULE2]
        disable iff (!NRST_I) fall_set && !wr_pend && !ce_reset |=> pend_r)
        else $error("fall lost");
    clear_wins_a: assert property (@(posedge CLK_SYS_I)               // [RULE14]
        disable iff (!NRST_I) wr_pend && !REG_WDATA_I[0] |=>
        !pend_r ##1 !ACCEPT_O.take)
        else $error("clear lost");
    ce_clears_pend_a: assert property (@(posedge CLK_SYS_I)           // [RULE17]
        disable iff (!NRST_I) ce_reset |=> !pend_r && CE_RESET_O)
        else $error("ce reset kept pending");
    push_one_level_a: assert property (@(posedge CLK_SYS_I)            // [RULE9]
        disable iff (!NRST_I) accept |=> sp_r == $past(sp_r) + SP_ONE)
        else $error("stack not pushed");
    ce_needs_rise_a: assert property (@(posedge CLK_SYS_I)            // [RULE20]
        disable iff (!NRST_I) ce_reset |-> ce_armed_r && carry_set_r)
        else $error("ce reset unarmed");
    no_nesting_a: assert property (@(posedge CLK_SYS_I)           // [RULE12]
        disable iff (!NRST_I) state_r == TIR_SERVICE |=> !ACCEPT_O.take)
        else $error("accept during service");
    held_pend_a: assert property (@(posedge CLK_SYS_I)             // [RULE6]
        disable iff (!NRST_I) pend_r && !(glob_on_r && permit_r)
        && !wr_pend && !ce_reset |=> pend_r)
        else $error("held request lost");
    wr_one_sets_a: assert property (@(posedge CLK_SYS_I)           // [RULE8]
        disable iff (!NRST_I) wr_pend && REG_WDATA_I[0] && !ce_reset
        |=> pend_r)
        else $error("written request lost");
    sel_fall_a: assert property (@(posedge CLK_SYS_I)             // [RULE13]
        disable iff (!NRST_I) wr_sel && !ce_reset && sel_pulse
        && !pulse_s2_r[REG_WDATA_I[SEL_W-1:0]] |=>
        fall_set || $changed(pulse_s2_r))
        else $error("select fall missed");
    single_set_a: assert property (@(posedge CLK_SYS_I)           // [RULE22]
        disable iff (!NRST_I) fall_set |=> !fall_set)
        else $error("fall held two cycles");
    restore_ctx_a: assert property (@(posedge CLK_SYS_I)          // [RULE21]
        disable iff (!NRST_I) pop && sp_r == SP_ONE |=>
        RESTORE_O && RESTORE_CTX_O == stack_r[0])
        else $error("wrong context restored");
endmodule

// ===== dv/tir_cpu_model.sv
/*
 * Partner model of the cpu instruction sequencer that faces the timer
 * interrupt logic: instruction strobes, ready level, context to save.
 * Assumes one system clock and strobes driven just after a rising edge.
 */
`timescale 1ns/1ps
module tir_cpu_model
    import tir_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                nrst_i,
    input  wire logic                slow_i,
    input  wire tir_pkg::tir_accept_t accept_i,
    output logic                     int_on_o,
    output logic                     int_off_o,
    output logic                     irq_ret_o,
    output logic                     ready_o,
    output tir_pkg::tir_ctx_t        ctx_o,
    output tir_pkg::tir_ctx_t        saved_o,
    output int                       accepts_o
);
    tir_ctx_t    last_ctx;
    logic [31:0] rnd;

    initial begin
        {int_on_o, int_off_o, irq_ret_o} = 3'h0;
        ready_o   = 1'b1;
        ctx_o     = '0;
        saved_o   = '0;
        accepts_o = 0;
    end

    // fresh context every cycle: a sample taken a cycle off restores
    // the wrong value; a busy cpu refuses every other cycle
    always @(posedge clk_i) begin
        rnd = $urandom;
        ready_o  <= slow_i ? ~ready_o : 1'b1;
        ctx_o    <= rnd[$bits(tir_ctx_t)-1:0];
        last_ctx <= ctx_o;
        if (!nrst_i) begin
            accepts_o <= 0;
        end else if (accept_i.take) begin
            accepts_o <= accepts_o + 1;
            saved_o   <= last_ctx; // context the logic sampled
        end
    end

    // one-cycle instruction strobe; service ends well inside one
    // pulse period, so no request is starved out
    task automatic strobe(input int which);
        @(posedge clk_i);
        case (which)
            0: int_on_o <= 1'b1;
            1: int_off_o <= 1'b1;
            default: irq_ret_o <= 1'b1; // only way back
        endcase
        @(posedge clk_i);
        {int_on_o, int_off_o, irq_ret_o} <= 3'h0;
    endtask
endmodule

// ===== dv/tb_timer_interrupt_logic.sv
/*
 * Self-checking bench for the timer interrupt request logic with a cpu
 * sequencer model. Assumes a 125 MHz clock; the 10 ms carry delay is
 * too long for this run, so carry and ce reset are only seen idle.
 */
`timescale 1ns/1ps
module tb_timer_interrupt_logic;
    import tir_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [3:0]  pulse = 4'hF;
    logic        ce_pin = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [3:0]  wdata = 4'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        slow = 1'b0;
    logic [3:0]  rdata;
    logic        int_on, int_off, irq_ret, ready, restore, carry;
    logic        ce_rst, off_st, pend;
    tir_ctx_t    ctx, rctx, saved, c1;
    tir_accept_t acc;
    int          accepts, miscompares, checked, s;
    logic [31:0] seed, d;

    always #4 clk = ~clk;

    tir_timer_irq i_dut (.CLK_SYS_I(clk), .NRST_I(nrst), .PULSE_I(pulse),
        .CE_PIN_I(ce_pin), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
        .GLOBAL_INT_ON_INSTR_I(int_on), .GLOBAL_INT_OFF_INSTR_I(int_off),
        .RETURN_FROM_IRQ_INSTR_I(irq_ret), .CPU_READY_I(ready),
        .CPU_CTX_I(ctx), .ACCEPT_O(acc), .RESTORE_CTX_O(rctx),
        .RESTORE_O(restore), .CARRY_SET_O(carry), .CE_RESET_O(ce_rst),
        .GLOBAL_INT_OFF_STATE_O(off_st), .TIMER_IRQ_PENDING_O(pend));

    tir_cpu_model i_cpu (.clk_i(clk), .nrst_i(nrst), .slow_i(slow),
        .accept_i(acc), .int_on_o(int_on), .int_off_o(int_off),
        .irq_ret_o(irq_ret), .ready_o(ready), .ctx_o(ctx),
        .saved_o(saved), .accepts_o(accepts));

    // ********************************************************************
    // checking and bus helpers
    // ********************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        if (miscompares == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic wrr(input logic [3:0] a, input logic [3:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [3:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
        chk(rdata, exp);
    endtask

    // status word worked out from ce level, service and enable
    function automatic logic [3:0] st(logic ce, logic svc, logic on);
        return {1'b0, ce, svc, on};
    endfunction

    // bounded wait for an event seen at a sampling edge
    task automatic wait_for(input int which, input int lim);
        repeat (lim) begin
            @(posedge clk);
            if (which == 0 && pend === 1'b1) break;
            if (which == 1 && acc.take === 1'b1) break;
            if (which == 2 && restore === 1'b1) break;
        end
    endtask

    task automatic exp_accept();
        wait_for(1, 12);
        chk(acc.take, 1'b1);
        chk(acc.vector, TIMER_VECT);
        chk(acc.seg, VECT_SEG);
        chk(pend, 1'b0);
        chk(off_st, 1'b1);
    endtask

    task automatic exp_restore(input tir_ctx_t c);
        i_cpu.strobe(2);
        wait_for(2, 6);
        chk(restore, 1'b1);
        chk(rctx, c);
    endtask

    initial begin
        #100000;
        miscompares++;
        results();
    end

    // ********************************************************************
    // scenarios
    // ********************************************************************
    initial begin
        seed = $urandom(32'h2765);
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk({pend, off_st, acc.take}, 3'h2);
        chk({carry, ce_rst, restore}, 3'h0);
        rdc(ADDR_PERMIT, 4'h0);
        rdc(ADDR_SEL, 4'h0);
        rdc(4'hF, 4'h0);
        rdc(ADDR_STATUS, st(1'b0, 1'b0, 1'b0));
        ce_pin <= 1'b1;
        // the pin needs two synchroniser flops before the read sees it
        repeat (2) @(posedge clk);
        rdc(ADDR_STATUS, st(1'b1, 1'b0, 1'b0));
        // each select: a fall on the next line and rising edges must not set pending
        for (s = 0; s < NUM_PULSES; s++) begin
            wrr(ADDR_SEL, 4'(s));
            pulse[(s + 1) % 4] <= 1'b0;
            repeat (8) @(posedge clk);
            chk(pend, 1'b0);
            pulse[s] <= 1'b0;
            wait_for(0, 8);
            chk(pend, 1'b1);
            wrr(ADDR_PEND, 4'h0);
            @(posedge clk);
            chk(pend, 1'b0);
            pulse <= 4'hF;
            repeat (8) @(posedge clk);
            chk(pend, 1'b0);
        end
        // reselecting onto a line that is low counts as a fall
        pulse[1] <= 1'b0;
        wrr(ADDR_SEL, 4'h0);
        repeat (6) @(posedge clk);
        wrr(ADDR_SEL, 4'h1);
        wait_for(0, 8);
        chk(pend, 1'b1);
        wrr(ADDR_SEL, 4'h0);
        pulse <= 4'hF;
        // random software writes land in the flag, nothing accepted
        i_cpu.strobe(0);
        repeat (6) begin
            d = $urandom;
            wrr(ADDR_PEND, d[3:0]);
            rdc(ADDR_PEND, {3'h0, d[0]});
        end
        wrr(ADDR_PEND, 4'h1);
        repeat (10) @(posedge clk);
        chk(accepts, 0);
        chk(pend, 1'b1);
        slow <= 1'b1;
        wrr(ADDR_PERMIT, 4'h1);
        exp_accept();
        @(posedge clk);
        c1 = saved;
        // request during service is held pending until the return
        pulse[0] <= 1'b0;
        wait_for(0, 8);
        repeat (8) @(posedge clk);
        chk(accepts, 1);
        chk(pend, 1'b1);
        pulse <= 4'hF;
        // re-enable inside the routine: still held until the return
        i_cpu.strobe(0);
        repeat (8) @(posedge clk);
        chk(accepts, 1);
        exp_restore(c1);
        exp_accept();
        @(posedge clk);
        exp_restore(saved);
        // disable instruction holds a written request off
        i_cpu.strobe(0);
        i_cpu.strobe(1);
        wrr(ADDR_PEND, 4'h1);
        repeat (10) @(posedge clk);
        chk(accepts, 2);
        chk(off_st, 1'b1);
        results();
    end
endmodule
